// File: logic/smsc_defs.svh
`ifndef SMSC_DEFS_SVH
`define SMSC_DEFS_SVH
// ==========================================
// Widths
`define SMSC_CNT_W 11
`define SMSC_PIN_N 4
// ==========================================
// Frame
`define SMSC_LAST_EDGE 5'h10
`define SMSC_EDGE_ONE 5'h01
// ==========================================
// Reset values
`define SMSC_BYTE_RST 8'h00
`define SMSC_PIN_RST 4'h8
`define SMSC_EDGE_RST 5'h00
`define SMSC_CNT_RST 11'h000
`endif

// File: logic/smsc_pkg.sv
package smsc_pkg;
  // ==========================================
  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_EDGE} smsc_state_t;
endpackage

// File: logic/smsc_core.sv
// What this block does
// - Phase-1 controller presents first data bit at load, waits half SCK, then gives first edge.
// - Sixteen edges per byte; latch on even edges, shift on odd, bit order selectable.
// - Received byte copied to output buffer only after final bit; then done flag.
// - Controller done flag rises half SCK period after the last edge.
// - Controller starts a waiting byte immediately at completion, no gap, unless a received byte is still unread.
// - All-zero selects divide by two; rate one, prescale zero divides by four.
// - Prescale value multiplies the rate divisor by value plus one.
// - Divider runs only as controller during a transfer.
// - Select output with fault detect drives SS low while busy; fault detect off.
// - Single-wire mode uses MOSI as controller, MISO as peripheral; other released.
// - Shared-pin drive enable sets direction; pin always feeds shift input.
// - SCK out as controller, in as peripheral; SS input as peripheral.
// - Controller with fault detect sets mode fault when SS goes low.
// - Without fault detect, or as peripheral, SS never raises a mode fault.
// - Mode fault forces peripheral, pins released, transfer aborted, byte discarded.
// - Mode fault also clears shared-pin drive enable.
// - Status read seeing fault, then control one write, clears mode fault.
// - Module disabled holds engine idle; control bits stay writable.
// - Halt-in-wait with wait stops clock generation; otherwise runs normally.
// - Controller transfer freezes during wait and resumes where it stopped.
// - Peripheral drops a pending byte at wait entry; completion deferred to exit.
// - Idle wait produces no done flag and no buffer copy.
// - Mode fault clears the controller select bit.
// - Enabled module ORs fault, done and tx-empty into one request.
`timescale 1ns/1ps
`include "smsc_defs.svh"
module smsc_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control register one
  input wire logic ctrlOneWr,
  input wire logic moduleEnableIn,
  input wire logic controllerSelIn,
  input wire logic selectOutputEnIn,
  input wire logic faultDetectEnIn,
  input wire logic lsbFirstSelIn,
  // Control register two
  input wire logic ctrlTwoWr,
  input wire logic singleWireSelIn,
  input wire logic sharedPinDriveEnIn,
  input wire logic haltInWaitIn,
  // Baud selects and processor wait
  input wire logic [2:0] prescaleSel,
  input wire logic [2:0] rateSel,
  input wire logic cpuWait,
  // Status
  input wire logic statusRd,
  output logic xferDoneFlag,
  output logic modeFaultFlag,
  output logic txEmptyFlag,
  output logic irqReq,
  output logic controllerSel,
  output logic sharedPinDriveEn,
  // Transmit data
  input wire logic txWr,
  input wire logic [7:0] txData,
  // Receive stream
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  // Serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic ssIn,
  output logic ssOut,
  output logic select_output_en
);

  // ==========================================
  // Helpers
  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic b, input logic lsb);
    shiftIn = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  function automatic logic [10:0] halfDivisor(input logic [2:0] pre, input logic [2:0] rate);
    halfDivisor = ({8'h00, pre} + 11'h001) << rate;
  endfunction

  // ==========================================
  // Pin synchronisers
  logic [3:0] rawPins;
  logic [3:0] syncA_q, syncB_q, syncC_q, pinS_q;
  logic sckS, mosiS, misoS, ssS;
  localparam logic [3:0] PinRstVal = `SMSC_PIN_RST;
  assign rawPins = {ssIn, misoIn, mosiIn, sckIn};
  assign sckS = pinS_q[0];
  assign mosiS = pinS_q[1];
  assign misoS = pinS_q[2];
  assign ssS = pinS_q[3];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_q <= `SMSC_PIN_RST;
      syncB_q <= `SMSC_PIN_RST;
      syncC_q <= `SMSC_PIN_RST;
    end else begin
      syncA_q <= rawPins;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  for (genvar i = 0; i < `SMSC_PIN_N; i++) begin : g_filt
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pinS_q[i] <= PinRstVal[i];
      end else if (syncB_q[i] == syncC_q[i]) begin
        pinS_q[i] <= syncB_q[i];
      end
    end
  end

  // ==========================================
  // Engine and control state
  smsc_pkg::smsc_state_t state_q, state_d;
  logic [`SMSC_CNT_W-1:0] baudCnt_q, baudCnt_d, halfDiv;
  logic [4:0] edgeCnt_q, edgeCnt_d, nextEdge;
  logic [7:0] shift_q, shift_d, txHold_q, txHold_d, pendByte_q, pendByte_d, doneByte;
  logic [7:0] rxData_q, rxData_d, rxSpare_q, rxSpare_d;
  logic latch_q, latch_d, sckLvl_q, sckLvl_d, sckPrev_q, pend_q, pend_d;
  logic waitPrev_q, seen_q, seen_d, fault_q, fault_d, done_q, done_d, irq_q, irq_d;
  logic txEmpty_q, txEmpty_d, rxValid_q, rxValid_d, spareV_q, spareV_d;
  logic enable_q, enable_d, ctrlSel_q, ctrlSel_d, ssOutEn_q, ssOutEn_d;
  logic faultEn_q, faultEn_d, lsbFirst_q, lsbFirst_d, single_q, single_d;
  logic shared_q, shared_d, haltWait_q, haltWait_d;
  logic ctrlAct, waitHalt, tick, serIn, push, pop, faultEvt, sckEdge, load;

  assign ctrlAct = enable_q & ctrlSel_q;
  assign waitHalt = cpuWait & haltWait_q;
  assign halfDiv = halfDivisor(prescaleSel, rateSel);
  assign tick = (baudCnt_q == halfDiv - 11'h001);
  assign nextEdge = edgeCnt_q + `SMSC_EDGE_ONE;
  assign sckEdge = sckS != sckPrev_q;
  assign pop = rxValid_q & rxReady;
  assign serIn = ctrlSel_q ? (single_q ? mosiS : misoS) : (single_q ? misoS : mosiS);
  assign faultEvt = ctrlAct & faultEn_q & ~ssOutEn_q & ~ssS;

  always_comb begin
    state_d = state_q;
    baudCnt_d = baudCnt_q;
    edgeCnt_d = edgeCnt_q;
    shift_d = shift_q;
    latch_d = latch_q;
    sckLvl_d = sckLvl_q;
    pend_d = pend_q;
    pendByte_d = pendByte_q;
    doneByte = shiftIn(shift_q, latch_q, lsbFirst_q);
    push = 1'b0;
    load = 1'b0;
    if (!enable_q) begin
      state_d = smsc_pkg::ST_IDLE;
      baudCnt_d = `SMSC_CNT_RST;
      edgeCnt_d = `SMSC_EDGE_RST;
      sckLvl_d = 1'b0;
    end else if (ctrlSel_q) begin
      if (state_q != smsc_pkg::ST_IDLE && !waitHalt) begin
        baudCnt_d = tick ? `SMSC_CNT_RST : baudCnt_q + 11'h001;
      end
      case (state_q)
        smsc_pkg::ST_IDLE: begin
          baudCnt_d = `SMSC_CNT_RST;
          if (!txEmpty_q && !spareV_q && !waitHalt) begin
            load = 1'b1;
            shift_d = txHold_q;
            edgeCnt_d = `SMSC_EDGE_RST;
            state_d = smsc_pkg::ST_SYNC;
          end
        end
        smsc_pkg::ST_SYNC: begin
          if (tick && !waitHalt) begin
            edgeCnt_d = `SMSC_EDGE_ONE;
            sckLvl_d = ~sckLvl_q;
            state_d = smsc_pkg::ST_EDGE;
          end
        end
        smsc_pkg::ST_EDGE: begin
          if (tick && !waitHalt) begin
            if (edgeCnt_q == `SMSC_LAST_EDGE) begin
              push = 1'b1;
              if (!txEmpty_q && !rxValid_q) begin
                load = 1'b1;
                shift_d = txHold_q;
                edgeCnt_d = `SMSC_EDGE_ONE;
                sckLvl_d = ~sckLvl_q;
              end else begin
                state_d = smsc_pkg::ST_IDLE;
                edgeCnt_d = `SMSC_EDGE_RST;
              end
            end else begin
              edgeCnt_d = nextEdge;
              sckLvl_d = ~sckLvl_q;
              if (nextEdge[0]) begin
                shift_d = shiftIn(shift_q, latch_q, lsbFirst_q);
              end else begin
                latch_d = serIn;
              end
            end
          end
        end
        default: state_d = smsc_pkg::ST_IDLE;
      endcase
    end else begin
      baudCnt_d = `SMSC_CNT_RST;
      sckLvl_d = 1'b0;
      if (ssS) begin
        edgeCnt_d = `SMSC_EDGE_RST;
        state_d = smsc_pkg::ST_IDLE;
      end else if (sckEdge) begin
        edgeCnt_d = nextEdge;
        state_d = smsc_pkg::ST_EDGE;
        if (nextEdge == `SMSC_EDGE_ONE) begin
          load = ~txEmpty_q;
          shift_d = txEmpty_q ? shift_q : txHold_q;
        end else if (nextEdge[0]) begin
          shift_d = shiftIn(shift_q, latch_q, lsbFirst_q);
        end else begin
          latch_d = serIn;
        end
        if (nextEdge == `SMSC_LAST_EDGE) begin
          doneByte = shiftIn(shift_q, serIn, lsbFirst_q);
          edgeCnt_d = `SMSC_EDGE_RST;
          state_d = smsc_pkg::ST_IDLE;
          if (waitHalt) begin
            pend_d = 1'b1;
            pendByte_d = doneByte;
          end else begin
            push = 1'b1;
          end
        end
      end
      if (waitHalt && !waitPrev_q) begin
        pend_d = 1'b0;
      end else if (!waitHalt && pend_q) begin
        pend_d = 1'b0;
        doneByte = pendByte_q;
        push = 1'b1;
      end
    end
    if (faultEvt) begin
      state_d = smsc_pkg::ST_IDLE;
      baudCnt_d = `SMSC_CNT_RST;
      edgeCnt_d = `SMSC_EDGE_RST;
      sckLvl_d = 1'b0;
      push = 1'b0;
      load = 1'b0;
      shift_d = shift_q;
    end
  end

  // ==========================================
  // Control bits, flags and buffers
  always_comb begin
    enable_d = enable_q;
    ctrlSel_d = ctrlSel_q;
    ssOutEn_d = ssOutEn_q;
    faultEn_d = faultEn_q;
    lsbFirst_d = lsbFirst_q;
    single_d = single_q;
    shared_d = shared_q;
    haltWait_d = haltWait_q;
    seen_d = seen_q;
    fault_d = fault_q;
    done_d = done_q;
    txHold_d = txHold_q;
    txEmpty_d = txEmpty_q | load;
    rxData_d = rxData_q;
    rxValid_d = rxValid_q;
    rxSpare_d = rxSpare_q;
    spareV_d = spareV_q;
    if (ctrlOneWr) begin
      enable_d = moduleEnableIn;
      ctrlSel_d = controllerSelIn;
      ssOutEn_d = selectOutputEnIn;
      faultEn_d = faultDetectEnIn;
      lsbFirst_d = lsbFirstSelIn;
    end
    if (ctrlTwoWr) begin
      single_d = singleWireSelIn;
      shared_d = sharedPinDriveEnIn;
      haltWait_d = haltInWaitIn;
    end
    if (txWr && (txEmpty_q || load)) begin
      txHold_d = txData;
      txEmpty_d = 1'b0;
    end
    if (statusRd && fault_q) begin
      seen_d = 1'b1;
    end
    if (ctrlOneWr && seen_q) begin
      fault_d = 1'b0;
      seen_d = 1'b0;
    end
    if (faultEvt) begin
      fault_d = 1'b1;
      ctrlSel_d = 1'b0;
      shared_d = 1'b0;
    end
    if (pop) begin
      done_d = 1'b0;
      rxValid_d = spareV_q;
      rxData_d = rxSpare_q;
      spareV_d = 1'b0;
    end
    if (push) begin
      done_d = 1'b1;
      if (!rxValid_d) begin
        rxData_d = doneByte;
        rxValid_d = 1'b1;
      end else if (!spareV_d) begin
        rxSpare_d = doneByte;
        spareV_d = 1'b1;
      end
    end
    irq_d = enable_q & (fault_d | done_d | txEmpty_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= smsc_pkg::ST_IDLE;
      baudCnt_q <= `SMSC_CNT_RST;
      edgeCnt_q <= `SMSC_EDGE_RST;
      shift_q <= `SMSC_BYTE_RST;
      txHold_q <= `SMSC_BYTE_RST;
      pendByte_q <= `SMSC_BYTE_RST;
      rxData_q <= `SMSC_BYTE_RST;
      rxSpare_q <= `SMSC_BYTE_RST;
      {latch_q, sckLvl_q, sckPrev_q, pend_q, waitPrev_q, seen_q} <= 6'h00;
      {fault_q, done_q, irq_q, rxValid_q, spareV_q} <= 5'h00;
      txEmpty_q <= 1'b1;
      {enable_q, ctrlSel_q, ssOutEn_q, faultEn_q, lsbFirst_q} <= 5'h00;
      {single_q, shared_q, haltWait_q} <= 3'h0;
    end else begin
      state_q <= state_d;
      baudCnt_q <= baudCnt_d;
      edgeCnt_q <= edgeCnt_d;
      shift_q <= shift_d;
      txHold_q <= txHold_d;
      pendByte_q <= pendByte_d;
      rxData_q <= rxData_d;
      rxSpare_q <= rxSpare_d;
      {latch_q, sckLvl_q, sckPrev_q} <= {latch_d, sckLvl_d, sckS};
      {pend_q, waitPrev_q, seen_q} <= {pend_d, waitHalt, seen_d};
      {fault_q, done_q, irq_q, rxValid_q, spareV_q} <= {fault_d, done_d, irq_d, rxValid_d, spareV_d};
      txEmpty_q <= txEmpty_d;
      {enable_q, ctrlSel_q, ssOutEn_q, faultEn_q, lsbFirst_q} <=
        {enable_d, ctrlSel_d, ssOutEn_d, faultEn_d, lsbFirst_d};
      {single_q, shared_q, haltWait_q} <= {single_d, shared_d, haltWait_d};
    end
  end

  // ==========================================
  // Pin drivers
  logic sckOut_q, sckOe_q, mosiOut_q, mosiOe_q, misoOut_q, misoOe_q, ssOut_q, select_output_en_q;
  logic outBit, periphDrive, autoSs;
  assign outBit = lsbFirst_q ? shift_q[0] : shift_q[7];
  assign periphDrive = enable_q & ~ctrlSel_q & ~fault_q & ~ssS;
  assign autoSs = ctrlAct & ssOutEn_q & faultEn_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sckOut_q, sckOe_q, mosiOut_q, mosiOe_q} <= 4'h0;
      {misoOut_q, misoOe_q, ssOut_q, select_output_en_q} <= 4'h2;
    end else begin
      sckOut_q <= sckLvl_d;
      sckOe_q <= ctrlAct & ~faultEvt;
      ssOut_q <= (state_d == smsc_pkg::ST_IDLE);
      select_output_en_q <= autoSs;
      mosiOut_q <= outBit;
      mosiOe_q <= ctrlAct & ~faultEvt & (~single_q | shared_q);
      misoOut_q <= outBit;
      misoOe_q <= periphDrive & (~single_q | shared_q);
    end
  end

  assign {sckOut, sckOe, mosiOut, mosiOe} = {sckOut_q, sckOe_q, mosiOut_q, mosiOe_q};
  assign {misoOut, misoOe, ssOut, select_output_en} = {misoOut_q, misoOe_q, ssOut_q, select_output_en_q};
  assign {xferDoneFlag, modeFaultFlag, txEmptyFlag, irqReq} = {done_q, fault_q, txEmpty_q, irq_q};
  assign {controllerSel, sharedPinDriveEn, rxData, rxValid} = {ctrlSel_q, shared_q, rxData_q, rxValid_q};

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fault_drops_ctrl: assert property ($rose(fault_q) |-> !ctrlSel_q && !shared_q)
    else $error("Mode fault left controller select set");
  a_fault_cause: assert property ($rose(fault_q) |-> $past(ctrlAct && faultEn_q && !ssOutEn_q))
    else $error("Mode fault without enabled controller");
  a_fault_idle: assert property ($rose(fault_q) |-> state_q == smsc_pkg::ST_IDLE && edgeCnt_q == 5'h00)
    else $error("Mode fault did not abort the transfer");
  a_div_idle: assert property (state_q == smsc_pkg::ST_IDLE |-> baudCnt_q == 11'h000)
    else $error("Divider running while idle");
  a_edge_bound: assert property (edgeCnt_q <= 5'h10)
    else $error("Edge count beyond sixteen");
  a_ss_busy: assert property (autoSs && state_q != smsc_pkg::ST_IDLE |-> !ssOut)
    else $error("Select not low during transfer");
  a_wait_freeze: assert property (ctrlAct && waitHalt && !faultEvt |=> $stable(edgeCnt_q) && $stable(shift_q))
    else $error("Controller transfer moved during wait");
  a_single_miso: assert property (ctrlAct && single_q |=> !misoOe)
    else $error("Controller drove MISO in single-wire mode");
  a_sck_periph: assert property (!ctrlSel_q && !$past(ctrlSel_q) |-> !sckOe)
    else $error("Peripheral drove SCK");
  a_done_tail: assert property (ctrlAct && state_q == smsc_pkg::ST_EDGE && edgeCnt_q == 5'h10 && !waitHalt
      && !faultEvt ##0 tick |=> done_q)
    else $error("Done flag missing after last edge");

  c_ctrl_byte: cover property (ctrlAct && $rose(done_q));
  c_back_to_back: cover property (push && load && ctrlAct);
  c_mode_fault: cover property ($rose(fault_q));
  c_periph_byte: cover property (!ctrlSel_q && $rose(done_q));

endmodule

// File: dv/smsc_peer_model.sv
`timescale 1ns/1ps
module smsc_peer_model (
  // Pins as the peer sees them
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic mosiIn,
  input wire logic lsbFirst,
  // Peer results
  output logic misoBit,
  output logic [7:0] got,
  output int gotCount
);
  // ==========================================
  // Phase-one peripheral
  logic [7:0] txQ[$];
  logic [7:0] shiftOut;
  logic [7:0] shiftIn;
  int edgeNum;
  initial begin
    misoBit = 1'b0;
    got = 8'h00;
    gotCount = 0;
    edgeNum = 0;
    shiftOut = 8'h00;
    shiftIn = 8'h00;
  end
  // Aborted frame is forgotten, MISO bit inverted
  always @(negedge sckOe) begin
    edgeNum = 0;
    misoBit = ~misoBit;
  end
  always @(sckOut) begin
    if (sckOe === 1'b1) begin
      edgeNum++;
      if (edgeNum == 1) begin
        shiftOut = (txQ.size() > 0) ? txQ.pop_front() : 8'h00;
      end
      if (edgeNum % 2 == 1) begin
        misoBit = lsbFirst ? shiftOut[(edgeNum - 1) / 2] : shiftOut[7 - (edgeNum - 1) / 2];
      end else begin
        shiftIn = lsbFirst ? {mosiIn, shiftIn[7:1]} : {shiftIn[6:0], mosiIn};
      end
      if (edgeNum == 16) begin
        got = shiftIn;
        gotCount++;
        edgeNum = 0;
        misoBit = ~misoBit;
      end
    end
  end
endmodule

// File: dv/test_spi_master_slave_core.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin testsRun++; if ((a) !== (b)) begin numErrors++; $display("BAD %0t %s", $time, m); end end
module test_spi_master_slave_core;
  // ==========================================
  // Signals
  logic clk, rst, ctrlOneWr, moduleEnableIn, controllerSelIn, selectOutputEnIn;
  logic faultDetectEnIn, lsbFirstSelIn, ctrlTwoWr, singleWireSelIn, sharedPinDriveEnIn;
  logic haltInWaitIn, cpuWait, statusRd, xferDoneFlag, modeFaultFlag, txEmptyFlag, irqReq;
  logic controllerSel, sharedPinDriveEn, txWr, rxValid, rxReady;
  logic [2:0] prescaleSel, rateSel;
  logic [7:0] txData, rxData, peerGot;
  logic sckIn, sckOut, sckOe, mosiIn, mosiOut, mosiOe, misoIn, misoOut, misoOe;
  logic ssIn, ssOut, select_output_en, peerMiso;
  bit pSck, pMosi;
  logic [7:0] pb, pm, pg;
  int numErrors = 0;
  int testsRun = 0;
  int nPop = 0;
  int peerCnt, h, n, k, i;
  bit dataChk, ssAuto, ssForce;
  realtime edgeT[$];
  realtime tDone;
  logic [7:0] expRx[$];
  logic [7:0] expPeer[$];
  logic [5:0] cfg [8] = '{6'h00, 6'h01, 6'h08, 6'h11, 6'h20, 6'h03, 6'h0B, 6'h12};
  // ==========================================
  // Pins: released MOSI shows inverse unless forced, SS pulled up
  assign sckIn = sckOe ? sckOut : pSck;
  assign mosiIn = mosiOe ? mosiOut : (ssForce ? pMosi : ~mosiOut);
  assign misoIn = misoOe ? misoOut : peerMiso;
  assign ssIn = select_output_en ? ssOut : ~ssForce;
  smsc_core i_dut (.clk, .rst, .ctrlOneWr, .moduleEnableIn,
    .controllerSelIn, .selectOutputEnIn, .faultDetectEnIn, .lsbFirstSelIn, .ctrlTwoWr,
    .singleWireSelIn, .sharedPinDriveEnIn, .haltInWaitIn, .prescaleSel, .rateSel, .cpuWait,
    .statusRd, .xferDoneFlag, .modeFaultFlag, .txEmptyFlag, .irqReq, .controllerSel,
    .sharedPinDriveEn, .txWr, .txData, .rxData, .rxValid, .rxReady, .sckIn, .sckOut, .sckOe,
    .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .ssIn, .ssOut, .select_output_en);
  smsc_peer_model i_peer (.sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn),
    .lsbFirst(lsbFirstSelIn), .misoBit(peerMiso), .got(peerGot), .gotCount(peerCnt));
  // ==========================================
  // Monitors
  always @(sckOut) begin
    if (sckOe === 1'b1) begin
      edgeT.push_back($realtime);
      if (ssAuto) `CHK({ssOut, select_output_en}, 2'b01, "select not low")
    end
  end
  always @(posedge xferDoneFlag) tDone = $realtime;
  always @(negedge clk) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) begin
      nPop++;
      if (dataChk) `CHK(rxData, expRx.pop_front(), "rx byte")
    end
  end
  always @(peerCnt) if (dataChk) `CHK(peerGot, expPeer.pop_front(), "peer byte")
  // ==========================================
  // Tasks
  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic ctl1(logic en, logic ms, logic so, logic fd, logic lsb);
    {moduleEnableIn, controllerSelIn, selectOutputEnIn, faultDetectEnIn, lsbFirstSelIn} =
      {en, ms, so, fd, lsb};
    ctrlOneWr = 1'b1;
    tick(1);
    ctrlOneWr = 1'b0;
    tick(1);
  endtask
  task automatic ctl2(logic sw, logic de, logic hw);
    {singleWireSelIn, sharedPinDriveEnIn, haltInWaitIn} = {sw, de, hw};
    ctrlTwoWr = 1'b1;
    tick(1);
    ctrlTwoWr = 1'b0;
    tick(1);
  endtask
  task automatic wrTx(logic [7:0] b);
    int j;
    for (j = 0; j < 2000 && txEmptyFlag !== 1'b1; j++) tick(1);
    `CHK(j < 2000, 1'b1, "tx slot never free")
    txData = b;
    txWr = 1'b1;
    tick(1);
    txWr = 1'b0;
  endtask
  task automatic send(logic [7:0] b);
    logic [7:0] p;
    p = $urandom;
    if (dataChk) begin
      i_peer.txQ.push_back(p);
      expRx.push_back(p);
      expPeer.push_back(b);
    end
    wrTx(b);
  endtask
  task automatic waitPop(int c);
    int j;
    for (j = 0; j < 3000 && nPop < c; j++) tick(1);
    `CHK(nPop, c, "byte count")
  endtask
  task automatic chkGaps(int c, int g);
    `CHK(edgeT.size(), c, "edge count")
    for (int e = 1; e < edgeT.size(); e++) begin
      `CHK(int'((edgeT[e] - edgeT[e - 1]) / 25.0), g, "gap")
    end
  endtask
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 30000);
    numErrors++;
    testDone();
  end
  initial begin
    {rst, ctrlOneWr, moduleEnableIn, controllerSelIn, selectOutputEnIn, faultDetectEnIn} = 6'h20;
    {lsbFirstSelIn, ctrlTwoWr, singleWireSelIn, sharedPinDriveEnIn, haltInWaitIn} = 5'h00;
    {cpuWait, statusRd, txWr, rxReady, prescaleSel, rateSel, txData} = 18'h00000;
    void'($urandom(32'h8f00));
    repeat (12) @(posedge clk);
    `CHK({txEmptyFlag, ssOut, irqReq}, 3'h6, "reset idle")
    `CHK({xferDoneFlag, modeFaultFlag, controllerSel}, 3'h0, "reset flags")
    #2 rst = 1'b0;
    rxReady = 1'b1;
    tick(6);
    ctl1(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    `CHK({irqReq, controllerSel, sckOe}, 3'h7, "enabled idle")
    for (int c = 0; c < 8; c++) begin
      {prescaleSel, rateSel} = cfg[c];
      h = (int'(prescaleSel) + 1) << rateSel;
      dataChk = (h >= 12);
      ctl1(1'b1, 1'b1, 1'b0, 1'b0, c[0]);
      edgeT.delete();
      n = nPop;
      send($urandom);
      waitPop(n + 1);
      chkGaps(16, h);
      `CHK(int'((tDone - edgeT[15]) / 25.0), h, "done delay")
    end
    ctl1(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    {cpuWait, ssAuto, n} = {2'b11, nPop};
    edgeT.delete();
    send($urandom);
    send($urandom);
    waitPop(n + 2);
    chkGaps(32, 12);
    {cpuWait, ssAuto} = 2'b00;
    `CHK({ssOut, select_output_en}, 2'b11, "select idle")
    ctl1(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    {rxReady, n} = {1'b0, nPop};
    edgeT.delete();
    repeat (3) send($urandom);
    tick(450);
    `CHK(edgeT.size(), 32, "third byte held")
    `CHK({rxValid, xferDoneFlag, irqReq, txEmptyFlag}, 4'hE, "buffer full")
    rxReady = 1'b1;
    waitPop(n + 3);
    `CHK(edgeT.size(), 48, "drain")
    ctl2(1'b0, 1'b0, 1'b1);
    n = nPop;
    edgeT.delete();
    send($urandom);
    for (i = 0; i < 500 && edgeT.size() < 5; i++) tick(1);
    cpuWait = 1'b1;
    tick(4);
    k = edgeT.size();
    tick(100);
    `CHK(edgeT.size(), k, "frozen")
    cpuWait = 1'b0;
    waitPop(n + 1);
    `CHK(edgeT.size(), 16, "resumed")
    ctl2(1'b0, 1'b0, 1'b0);
    ctl1(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    `CHK(irqReq, 1'b0, "disabled request")
    n = nPop;
    edgeT.delete();
    send($urandom);
    tick(60);
    `CHK(edgeT.size(), 0, "disabled idle")
    ctl1(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    waitPop(n + 1);
    ssForce = 1'b1;
    tick(20);
    `CHK(modeFaultFlag, 1'b0, "fault ignored")
    ssForce = 1'b0;
    tick(8);
    ctl2(1'b1, 1'b1, 1'b0);
    ctl1(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    n = nPop;
    edgeT.delete();
    wrTx(8'h5A);
    for (i = 0; i < 500 && edgeT.size() < 6; i++) tick(1);
    `CHK({mosiOe, misoOe}, 2'b10, "shared pin")
    ssForce = 1'b1;
    for (i = 0; i < 20 && modeFaultFlag !== 1'b1; i++) tick(1);
    tick(1);
    `CHK({modeFaultFlag, controllerSel, sharedPinDriveEn}, 3'h4, "fault")
    `CHK({sckOe, mosiOe, irqReq}, 3'h1, "fault pins")
    k = edgeT.size();
    tick(300);
    `CHK({edgeT.size(), nPop}, {k, n}, "aborted")
    ssForce = 1'b0;
    tick(8);
    ctl1(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    `CHK(modeFaultFlag, 1'b1, "clear needs read")
    statusRd = 1'b1;
    tick(1);
    statusRd = 1'b0;
    ctl1(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    `CHK({modeFaultFlag, controllerSel}, 2'b01, "fault cleared")
    ctl2(1'b0, 1'b0, 1'b1);
    ctl1(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(sckOe, 1'b0, "peripheral clock in")
    cpuWait = 1'b1;
    tick(20);
    cpuWait = 1'b0;
    tick(20);
    `CHK({xferDoneFlag, rxValid}, 2'b00, "idle wait")
    // Peripheral byte, completion held by wait
    n = nPop;
    pb = 8'($urandom);
    pm = 8'($urandom);
    wrTx(pb);
    expRx.push_back(pm);
    {cpuWait, ssForce} = 2'b11;
    tick(12);
    for (int e = 1; e <= 16; e++) begin
      if (e % 2 == 0) pg = {pg[6:0], misoIn};
      pSck = ~pSck;
      if (e % 2 == 1) pMosi = pm[7 - (e - 1) / 2];
      tick(12);
    end
    `CHK({rxValid, xferDoneFlag}, 2'b00, "held in wait")
    cpuWait = 1'b0;
    waitPop(n + 1);
    `CHK(pg, pb, "peripheral out")
    ssForce = 1'b0;
    tick(8);
    testDone();
  end
endmodule
